// ### logic/hbd_pkg.sv
package hbd_pkg;

	// ----------------------------------------
	// status/control register layout
	// ----------------------------------------
	localparam int unsigned SCR_W            = 8;
	localparam int unsigned SCR_ALLOW_POS    = 7;
	localparam int unsigned SCR_ACTIVE_POS   = 6;
	localparam int unsigned SCR_CLKSEL_POS   = 5;
	localparam int unsigned SCR_WAIT_POS     = 4;
	localparam int unsigned SCR_WFAIL_POS    = 3;
	localparam int unsigned SCR_DFAIL_POS    = 2;
	localparam int unsigned SCR_SPARE1_POS   = 1;
	localparam int unsigned SCR_SPARE0_POS   = 0;
	localparam logic [7:0]  SCR_RESET        = 8'h00;
	localparam logic [7:0]  SCR_STATUS_MASK  = 8'h5C;
	localparam logic [7:0]  SCR_ALLOW_MASK   = 8'h80;
	localparam int unsigned MATCH_W          = 16;
	localparam logic [15:0] MATCH_RESET      = 16'h0000;

	// ----------------------------------------
	// serial command selectors
	// ----------------------------------------
	typedef enum logic [1:0]
	{
		HBD_CMD_NONE  = 2'b00,
		HBD_CMD_CTRL  = 2'b01,
		HBD_CMD_MATCH = 2'b10
	} hbd_cmd_t;

	typedef struct packed
	{
		logic        valid;
		hbd_cmd_t    cmd;
		logic [15:0] data;
	} hbd_ser_wr_t;

	typedef struct packed
	{
		logic wait_stop;
		logic wait_stop_fail;
		logic data_valid_fail;
	} hbd_core_stat_t;

	typedef enum logic [1:0]
	{
		HBD_BRK_NONE    = 2'b00,
		HBD_BRK_HALT    = 2'b01,
		HBD_BRK_SOFTINT = 2'b10
	} hbd_brk_kind_t;

endpackage

// ### logic/hbd_tag_queue.sv
`timescale 1ns/100ps
module hbd_tag_queue #(
	parameter int unsigned DEPTH = 3
)(
	input  wire logic i_sys_clk,
	input  wire logic i_srst,
	input  wire logic i_enq,
	input  wire logic i_enq_mark,
	input  wire logic i_deq,
	input  wire logic i_flush,
	output logic      o_head_mark
);
	localparam int unsigned      CNT_W    = $clog2(DEPTH + 1);
	localparam logic [CNT_W-1:0] FULL_CNT = CNT_W'(DEPTH);

	logic [DEPTH-1:0] mark_q;
	logic [DEPTH-1:0] mark_d;
	logic [CNT_W-1:0] cnt_q;
	logic [CNT_W-1:0] cnt_d;

	// ----------------------------------------
	// mark shift queue
	// ----------------------------------------
	always_comb
	begin
		mark_d = mark_q;
		cnt_d  = cnt_q;
		if (i_flush)
		begin
			mark_d = '0;
			cnt_d  = '0;
		end
		else
		begin
			if (i_deq && cnt_d != '0)
			begin
				mark_d = {1'b0, mark_d[DEPTH-1:1]};
				cnt_d  = cnt_d - 1'b1;
			end
			if (i_enq && cnt_d < FULL_CNT)
			begin
				mark_d[cnt_d] = i_enq_mark;
				cnt_d         = cnt_d + 1'b1;
			end
		end
	end

	always_ff @(posedge i_sys_clk)
	begin
		if (i_srst)
		begin
			mark_q <= '0;
			cnt_q  <= '0;
		end
		else
		begin
			mark_q <= mark_d;
			cnt_q  <= cnt_d;
		end
	end

	assign o_head_mark = (cnt_q != '0) && mark_q[0];

endmodule

// ### logic/hbd_debug_ctrl.sv
`timescale 1ns/100ps
module hbd_debug_ctrl #(
	parameter int unsigned QUEUE_DEPTH = 3
)(
	input  wire logic                    i_sys_clk,
	input  wire logic                    i_srst,
	input  wire logic                    i_breakpoint_request_enable,
	input  wire logic                    i_tag_select,
	input  wire logic                    i_trigger,
	input  wire logic                    i_queue_load,
	input  wire logic                    i_queue_advance,
	input  wire logic                    i_queue_flush,
	input  wire logic                    i_insn_done,
	input  wire logic                    i_background_exit,
	input  wire hbd_pkg::hbd_core_stat_t i_core_stat,
	input  wire hbd_pkg::hbd_ser_wr_t    i_ser_wr,
	output logic                         o_tag_suppress,
	output hbd_pkg::hbd_brk_kind_t       o_brk_kind,
	output logic                         o_background_active_flag,
	output logic [7:0]                   o_debug_status_control_register,
	output logic [15:0]                  o_debug_match_address_register,
	output logic                         o_clock_source_select
);
	logic [7:0]  ctrl_q;
	logic [7:0]  ctrl_d;
	logic [15:0] match_q;
	logic [15:0] match_d;
	logic        active_q;
	logic        active_d;
	logic        force_pend_q;
	logic        force_pend_d;
	hbd_pkg::hbd_core_stat_t stat_q;
	hbd_pkg::hbd_brk_kind_t  kind_q;
	hbd_pkg::hbd_brk_kind_t  kind_d;
	logic        brk_req;
	logic        head_mark;
	logic        take_brk;
	logic        allow;

	// ----------------------------------------
	// breakpoint request
	// ----------------------------------------
	// gate triggers by enable
	assign brk_req = i_breakpoint_request_enable && i_trigger;
	assign allow   = ctrl_q[hbd_pkg::SCR_ALLOW_POS];

	hbd_tag_queue #(
		.DEPTH       (QUEUE_DEPTH)
	) u_tag_queue (
		.i_sys_clk   (i_sys_clk),
		.i_srst      (i_srst),
		.i_enq       (i_queue_load),
		.i_enq_mark  (brk_req && i_tag_select),
		.i_deq       (i_queue_advance),
		.i_flush     (i_queue_flush),
		.o_head_mark (head_mark)
	);

	assign o_tag_suppress = head_mark && i_queue_advance && !i_queue_flush && !active_q;

	// ----------------------------------------
	// entry decision
	// ----------------------------------------
	always_comb
	begin
		force_pend_d = force_pend_q;
		take_brk     = 1'b0;
		if (brk_req && !i_tag_select && !active_q)
		begin
			force_pend_d = 1'b1;
		end
		if ((force_pend_d && i_insn_done) || o_tag_suppress)
		begin
			take_brk     = 1'b1;
			force_pend_d = 1'b0;
		end
		kind_d = hbd_pkg::HBD_BRK_NONE;
		if (take_brk)
		begin
			kind_d = allow ? hbd_pkg::HBD_BRK_HALT : hbd_pkg::HBD_BRK_SOFTINT;
		end
		active_d = active_q;
		if (i_background_exit)
		begin
			active_d = 1'b0;
		end
		if (kind_d == hbd_pkg::HBD_BRK_HALT)
		begin
			active_d = 1'b1;
		end
	end

	// ----------------------------------------
	// serial registers
	// ----------------------------------------
	always_comb
	begin
		ctrl_d  = ctrl_q;
		match_d = match_q;
		if (i_ser_wr.valid && i_ser_wr.cmd == hbd_pkg::HBD_CMD_CTRL)
		begin
			ctrl_d = (ctrl_q & (hbd_pkg::SCR_STATUS_MASK | hbd_pkg::SCR_ALLOW_MASK))
				| (i_ser_wr.data[7:0] & ~(hbd_pkg::SCR_STATUS_MASK | hbd_pkg::SCR_ALLOW_MASK));
			if (!active_q)
			begin
				ctrl_d[hbd_pkg::SCR_ALLOW_POS] = i_ser_wr.data[hbd_pkg::SCR_ALLOW_POS];
			end
		end
		if (i_ser_wr.valid && i_ser_wr.cmd == hbd_pkg::HBD_CMD_MATCH)
		begin
			match_d = i_ser_wr.data;
		end
	end

	always_ff @(posedge i_sys_clk)
	begin
		if (i_srst)
		begin
			ctrl_q       <= hbd_pkg::SCR_RESET;
			match_q      <= hbd_pkg::MATCH_RESET;
			active_q     <= 1'b0;
			force_pend_q <= 1'b0;
			kind_q       <= hbd_pkg::HBD_BRK_NONE;
			stat_q       <= '0;
		end
		else
		begin
			ctrl_q       <= ctrl_d;
			match_q      <= match_d;
			active_q     <= active_d;
			force_pend_q <= force_pend_d;
			kind_q       <= kind_d;
			stat_q       <= i_core_stat;
		end
	end

	always_comb
	begin
		o_debug_status_control_register = ctrl_q & ~hbd_pkg::SCR_STATUS_MASK;
		o_debug_status_control_register[hbd_pkg::SCR_ACTIVE_POS] = active_q;
		o_debug_status_control_register[hbd_pkg::SCR_WAIT_POS]   = stat_q.wait_stop;
		o_debug_status_control_register[hbd_pkg::SCR_WFAIL_POS]  = stat_q.wait_stop_fail;
		o_debug_status_control_register[hbd_pkg::SCR_DFAIL_POS]  = stat_q.data_valid_fail;
	end

	assign o_debug_match_address_register = match_q;
	assign o_clock_source_select          = ctrl_q[hbd_pkg::SCR_CLKSEL_POS];
	assign o_background_active_flag       = active_q;
	assign o_brk_kind                     = kind_q;

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (i_srst);

	no_req_disabled_a : assert property (!i_breakpoint_request_enable && !force_pend_q && !head_mark
		|=> kind_q == hbd_pkg::HBD_BRK_NONE) else $error("breakpoint without enable");
	force_wait_a : assert property (force_pend_q && !i_insn_done && !o_tag_suppress
		|=> kind_q == hbd_pkg::HBD_BRK_NONE) else $error("force taken before completion");
	force_take_a : assert property (force_pend_q && i_insn_done
		|=> kind_q != hbd_pkg::HBD_BRK_NONE) else $error("force not taken");
	tag_no_force_a : assert property (brk_req && i_tag_select && !force_pend_q
		|=> !force_pend_q) else $error("tag request left force pending");
	tag_entry_a : assert property (o_tag_suppress && allow
		|=> kind_q == hbd_pkg::HBD_BRK_HALT && active_q) else $error("tag did not enter background");
	halt_active_a : assert property (kind_q == hbd_pkg::HBD_BRK_HALT |-> active_q)
		else $error("background entry without active flag");
	soft_int_fallback_a : assert property (take_brk && !allow
		|=> kind_q == hbd_pkg::HBD_BRK_SOFTINT && !active_q) else $error("no interrupt fallback");
	allow_lock_a : assert property (active_q && !i_srst
		|=> ctrl_q[hbd_pkg::SCR_ALLOW_POS] == $past(ctrl_q[hbd_pkg::SCR_ALLOW_POS]))
		else $error("allow bit changed in background");
	status_ro_a : assert property (i_ser_wr.valid && i_ser_wr.cmd == hbd_pkg::HBD_CMD_CTRL
		&& !i_background_exit && kind_d != hbd_pkg::HBD_BRK_HALT
		|=> o_background_active_flag == $past(active_q)) else $error("status written by control");
	status_bits_a : assert property (i_ser_wr.valid && i_ser_wr.cmd == hbd_pkg::HBD_CMD_CTRL
		|=> o_debug_status_control_register[hbd_pkg::SCR_WAIT_POS:hbd_pkg::SCR_DFAIL_POS] == $past(i_core_stat))
		else $error("status bits written by control");
	clksel_wr_a : assert property (i_ser_wr.valid && i_ser_wr.cmd == hbd_pkg::HBD_CMD_CTRL
		|=> o_clock_source_select == $past(i_ser_wr.data[hbd_pkg::SCR_CLKSEL_POS]))
		else $error("clock select write lost");
	clksel_hold_a : assert property (!(i_ser_wr.valid && i_ser_wr.cmd == hbd_pkg::HBD_CMD_CTRL)
		|=> $stable(o_clock_source_select)) else $error("clock select changed without write");
	match_wr_a : assert property (i_ser_wr.valid && i_ser_wr.cmd == hbd_pkg::HBD_CMD_MATCH
		|=> o_debug_match_address_register == $past(i_ser_wr.data)) else $error("match write lost");
	match_hold_a : assert property (!(i_ser_wr.valid && i_ser_wr.cmd == hbd_pkg::HBD_CMD_MATCH)
		|=> $stable(o_debug_match_address_register)) else $error("match changed without serial write");
	flush_drop_a : assert property (i_queue_flush |=> !head_mark) else $error("mark survived flush");

	// ----------------------------------------
	// cover points
	// ----------------------------------------
	tag_entry_c : cover property (o_tag_suppress ##1 kind_q == hbd_pkg::HBD_BRK_HALT);
	force_entry_c : cover property (force_pend_q && i_insn_done);
	soft_int_c : cover property (kind_q == hbd_pkg::HBD_BRK_SOFTINT);
	locked_write_c : cover property (active_q && i_ser_wr.valid && i_ser_wr.cmd == hbd_pkg::HBD_CMD_CTRL);

endmodule

// ### sim/hbd_cpu_model.sv
`timescale 1ns/100ps
module hbd_cpu_model (
	input  wire logic                   i_sys_clk,
	input  wire logic                   i_srst,
	input  wire hbd_pkg::hbd_brk_kind_t i_brk_kind,
	input  wire logic                   i_stay,
	output logic                        o_insn_done,
	output logic                        o_background_exit
);
	logic [1:0] cnt_q;
	logic       bg_q;
	always_ff @(posedge i_sys_clk)
	begin
		cnt_q <= (i_srst || cnt_q == 2'h2) ? 2'h0 : cnt_q + 2'h1;
	end
	assign o_insn_done = (cnt_q == 2'h2);
	// background entered only on HBD_BRK_HALT
	always_ff @(posedge i_sys_clk)
	begin
		if (i_srst || o_background_exit)
			bg_q <= 1'b0;
		else if (i_brk_kind == hbd_pkg::HBD_BRK_HALT)
			bg_q <= 1'b1;
	end
	assign o_background_exit = bg_q && !i_stay;
endmodule

// ### sim/hw_breakpoint_debug_ctrl_tb.sv
`timescale 1ns/100ps
module hw_breakpoint_debug_ctrl_tb;
	logic                    clk = 1'b0;
	logic                    srst = 1'b1;
	logic                    en = 1'b0, tsel = 1'b0, trig = 1'b0, load = 1'b0, adv = 1'b0, flush = 1'b0;
	logic                    stay = 1'b1, allow_m = 1'b0;
	logic                    insn_done, bg_exit, suppress, active, clksel;
	hbd_pkg::hbd_core_stat_t stat = '0;
	hbd_pkg::hbd_ser_wr_t    wr = '0;
	hbd_pkg::hbd_brk_kind_t  kind;
	logic [7:0]              scr;
	logic [15:0]             match, r16;
	int                      errors = 0, checks_done = 0;

	always #2.5 clk = ~clk;

	hbd_debug_ctrl u_dut (.i_sys_clk(clk), .i_srst(srst), .i_breakpoint_request_enable(en),
		.i_tag_select(tsel), .i_trigger(trig), .i_queue_load(load), .i_queue_advance(adv),
		.i_queue_flush(flush), .i_insn_done(insn_done), .i_background_exit(bg_exit), .i_core_stat(stat),
		.i_ser_wr(wr), .o_tag_suppress(suppress), .o_brk_kind(kind), .o_background_active_flag(active),
		.o_debug_status_control_register(scr), .o_debug_match_address_register(match),
		.o_clock_source_select(clksel));

	hbd_cpu_model u_cpu (.i_sys_clk(clk), .i_srst(srst), .i_brk_kind(kind), .i_stay(stay),
		.o_insn_done(insn_done), .o_background_exit(bg_exit));

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			errors++;
			$display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
		end
	endtask

	task automatic finish_test();
		$display("errors=%0d checks_done=%0d", errors, checks_done);
		if (errors == 0 && checks_done > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	function automatic logic [15:0] exp_scr(input logic [7:0] d, input logic act);
		allow_m = act ? allow_m : d[7];
		return {8'h00, allow_m, act, d[5], stat, d[1:0]};
	endfunction

	task automatic ser(input hbd_pkg::hbd_cmd_t cmd, input logic [15:0] d);
		@(posedge clk);
		wr <= '{valid: 1'b1, cmd: cmd, data: d};
		@(posedge clk);
		wr <= '0;
		#1;
	endtask

	task automatic force_trig(input logic e, input logic ts);
		@(posedge clk);
		en <= e;
		tsel <= ts;
		trig <= 1'b1;
		@(posedge clk);
		trig <= 1'b0;
	endtask

	task automatic wait_brk(input hbd_pkg::hbd_brk_kind_t exp);
		hbd_pkg::hbd_brk_kind_t got;
		got = hbd_pkg::HBD_BRK_NONE;
		repeat (10)
		begin
			#1;
			if (got == hbd_pkg::HBD_BRK_NONE)
				got = kind;
			@(posedge clk);
		end
		check(16'(got), 16'(exp));
	endtask

	task automatic q_step(input logic l, input logic t, input logic a, input logic f);
		@(posedge clk);
		load <= l;
		trig <= t;
		adv <= a;
		flush <= f;
		#1;
	endtask

	task automatic leave_bg();
		@(posedge clk);
		stay <= 1'b0;
		repeat (3) @(posedge clk);
		stay <= 1'b1;
		#1;
		check(16'(active), 16'h0000);
	endtask

	initial
	begin
		void'($urandom(25241));
		repeat (10) @(posedge clk);
		srst <= 1'b0;
		stat <= 3'($urandom);
		#1;
		check(16'(scr), 16'(hbd_pkg::SCR_RESET));
		check(match, hbd_pkg::MATCH_RESET);
		for (int i = 0; i < 6; i++)
		begin
			r16 = 16'($urandom);
			ser(hbd_pkg::HBD_CMD_MATCH, r16);
			check(match, r16);
			r16 = 16'($urandom);
			ser(hbd_pkg::HBD_CMD_CTRL, r16);
			check(16'(scr), exp_scr(r16[7:0], 1'b0));
		end
		ser(hbd_pkg::HBD_CMD_CTRL, 16'h0000);
		check(16'(scr), exp_scr(8'h00, 1'b0));
		force_trig(1'b0, 1'b0);
		wait_brk(hbd_pkg::HBD_BRK_NONE);
		force_trig(1'b1, 1'b0);
		wait_brk(hbd_pkg::HBD_BRK_SOFTINT);
		ser(hbd_pkg::HBD_CMD_CTRL, 16'h0080);
		check(16'(scr), exp_scr(8'h80, 1'b0));
		force_trig(1'b1, 1'b0);
		wait_brk(hbd_pkg::HBD_BRK_HALT);
		check(16'(active), 16'h0001);
		ser(hbd_pkg::HBD_CMD_CTRL, 16'h0020);
		check(16'(scr), exp_scr(8'h20, 1'b1));
		check(16'(clksel), 16'h0001);
		leave_bg();
		force_trig(1'b1, 1'b1);
		q_step(1'b1, 1'b1, 1'b0, 1'b0);
		q_step(1'b0, 1'b0, 1'b1, 1'b0);
		check(16'(suppress), 16'h0001);
		q_step(1'b0, 1'b0, 1'b0, 1'b0);
		wait_brk(hbd_pkg::HBD_BRK_HALT);
		leave_bg();
		q_step(1'b1, 1'b1, 1'b0, 1'b0);
		q_step(1'b0, 1'b0, 1'b0, 1'b1);
		q_step(1'b1, 1'b0, 1'b0, 1'b0);
		q_step(1'b0, 1'b0, 1'b1, 1'b0);
		check(16'(suppress), 16'h0000);
		q_step(1'b0, 1'b0, 1'b0, 1'b0);
		wait_brk(hbd_pkg::HBD_BRK_NONE);
		finish_test();
	end

	initial
	begin
		#50000;
		errors++;
		finish_test();
	end
endmodule
